// ===== hdl/sdcb_col_gen.sv
// Purpose: Column address of one burst beat.
// Assumes: Beat index counts from zero at the column command.
// Notes: Pure combinational; the core registers the result.
module sdcb_col_gen (
    input wire logic [7:0] start_i,
    input wire logic [7:0] beat_i,
    input wire logic [2:0] bl_i,
    input wire logic ilv_i,
    output logic [7:0] col_o
);
    // ======================================================================
    // Wrap mask of the burst-sized block.
    function automatic logic [7:0] wrap_mask(input logic [2:0] bl);
        case (bl)
            sdcb_pkg::BL_2: wrap_mask = 8'h01;
            sdcb_pkg::BL_4: wrap_mask = 8'h03;
            sdcb_pkg::BL_8: wrap_mask = 8'h07;
            sdcb_pkg::BL_PAGE: wrap_mask = 8'hff;
            default: wrap_mask = 8'h00;
        endcase
    endfunction

    logic [7:0] m;
    logic [7:0] sum;

    assign m = wrap_mask(bl_i);
    assign sum = start_i + beat_i;

    always_comb
    begin
        if (bl_i == sdcb_pkg::BL_PAGE)
            col_o = sum; // [RULE25]
        else if (ilv_i)
            col_o = start_i ^ (beat_i & m); // [RULE22]
        else
            col_o = (start_i & ~m) | (sum & m); // [RULE21]
    end
endmodule // sdcb_col_gen

// ===== hdl/sdcb_core.sv
// Purpose: Command decoder and burst sequencer of a four-bank 32-bit synchronous DRAM.
// Assumes: Controller pins change with CORE_CLK_I; storage array outside answers reads combinationally.
// Notes: Read data reaches the pins two or three cycles after its beat, per the programmed latency.
// Notes on behaviour
// [RULE1] Controller waits 200 us with masks and clock enable high, then precharges all.
// [RULE2] After precharge, controller programs mode and issues eight auto refreshes.
// [RULE3] Mode set only with all banks precharged and clock enable high before.
// [RULE4] All four strobes low loads mode parameters from the address pins.
// [RULE5] Controller waits the mode set cycle time after a mode set.
// [RULE6] Bank activated first; column access waits the row to column delay.
// [RULE7] Active bank precharged before reactivation; row cycle time respected.
// [RULE8] Activations of different banks are spaced by the bank to bank delay.
// [RULE9] No bank stays active beyond the maximum row active time.
// [RULE10] Column strobe low, row strobe high is an access; write enable picks direction.
// [RULE11] Another row in an open bank needs precharge then activation.
// [RULE12] Read or write commands are accepted on every cycle, any active bank.
// [RULE13] Burst order sequential or interleaved; lengths 1, 2, 4, 8 or page.
// [RULE14] Write data arrives with the command and each following edge; extra ignored.
// [RULE15] A read cuts a read burst; old data flows until new latency.
// [RULE16] Controller masks read data due in the first two cycles of a write.
// [RULE17] A write cuts a write burst and runs a full burst from the new column.
// [RULE18] A read ends a write burst at once; remaining write data is dropped.
// [RULE19] Burst stop ends a burst and leaves the bank open.
// [RULE20] After burst stop the read outputs float after the read latency.
// [RULE21] Sequential bursts wrap inside the burst-sized block with no carry above.
// [RULE22] Interleaved beat column is start column exclusive-ORed with beat index.
// [RULE23] Read mask floats a byte two cycles later; write mask blocks at once.
// [RULE24] Chip select high ignores new commands; running work continues.
// [RULE25] Page bursts step through the whole row, wrapping, until stopped.
module sdcb_core (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic CKE_I,
    input wire logic CS_N_I,
    input wire logic RAS_N_I,
    input wire logic CAS_N_I,
    input wire logic WE_N_I,
    input wire logic [1:0] BANK_SELECT_I,
    input wire logic [10:0] ADDR_I,
    input wire logic [3:0] DQM_I,
    input wire logic [31:0] DQ_I,
    output logic [31:0] DQ_O,
    output logic [3:0] DQ_OE_O,
    output sdcb_pkg::sdcb_mem_req_t MEM_REQ_O,
    input wire logic [31:0] MEM_RDATA_I
);
    // ======================================================================
    // Command decode
    logic cke_prev_reg;
    logic cmd_ok;
    logic [3:0] op;
    logic col_cmd;
    logic stop_cmd;
    logic pre_cmd;

    // A command counts only when clock enable was high the cycle before.
    assign op = {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I};
    assign cmd_ok = cke_prev_reg && !CS_N_I; // [RULE24]
    assign col_cmd = cmd_ok && (op == sdcb_pkg::OP_READ || op == sdcb_pkg::OP_WRITE); // [RULE10]
    assign stop_cmd = cmd_ok && op == sdcb_pkg::OP_BURST_STOP; // [RULE19]
    assign pre_cmd = cmd_ok && op == sdcb_pkg::OP_PRECHARGE;

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
            cke_prev_reg <= 1'b0;
        else
            cke_prev_reg <= CKE_I;
    end

    // ======================================================================
    // Mode register
    logic [2:0] bl_reg;
    logic ilv_reg;
    logic cl3_reg;

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            bl_reg <= sdcb_pkg::BL_RST;
            ilv_reg <= sdcb_pkg::BT_RST;
            cl3_reg <= sdcb_pkg::CL3_RST;
        end
        else if (cmd_ok && op == sdcb_pkg::OP_MODE_SET)
        begin
            bl_reg <= ADDR_I[sdcb_pkg::MR_BL_LSB +: 3]; // [RULE4] [RULE13]
            ilv_reg <= ADDR_I[sdcb_pkg::MR_BT_BIT];
            cl3_reg <= ADDR_I[sdcb_pkg::MR_CL_LSB +: 3] == sdcb_pkg::CL_THREE;
        end
    end

    // ======================================================================
    // Open rows, one per bank
    logic [10:0] row_reg [4];

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            for (int i = 0; i < sdcb_pkg::BANKS; i++)
                row_reg[i] <= 11'h000;
        end
        else if (cmd_ok && op == sdcb_pkg::OP_ACTIVATE)
            row_reg[BANK_SELECT_I] <= ADDR_I;
    end

    // ======================================================================
    // Burst sequencer
    sdcb_pkg::sdcb_burst_t state_reg;
    sdcb_pkg::sdcb_burst_t cur_kind;
    logic [1:0] bank_reg;
    logic [7:0] start_reg;
    logic [7:0] beat_reg;
    logic [1:0] cur_bank;
    logic [7:0] cur_start;
    logic [7:0] cur_beat;
    logic [7:0] cur_col;
    logic [7:0] last_beat;
    logic beat_on;
    logic last;

    // A column command always restarts the burst, so back to back commands
    // and interruptions in every direction share one path.
    always_comb
    begin
        if (col_cmd)
        begin
            cur_kind = WE_N_I ? sdcb_pkg::SDCB_READ : sdcb_pkg::SDCB_WRITE; // [RULE12] [RULE15] [RULE17] [RULE18]
            cur_bank = BANK_SELECT_I;
            cur_start = ADDR_I[7:0];
            cur_beat = 8'h00;
        end
        else
        begin
            cur_kind = state_reg;
            cur_bank = bank_reg;
            cur_start = start_reg;
            cur_beat = beat_reg;
        end
    end

    always_comb
    begin
        case (bl_reg)
            sdcb_pkg::BL_2: last_beat = 8'h01;
            sdcb_pkg::BL_4: last_beat = 8'h03;
            sdcb_pkg::BL_8: last_beat = 8'h07;
            default: last_beat = 8'h00;
        endcase
    end

    assign beat_on = col_cmd || (state_reg != sdcb_pkg::SDCB_IDLE && !stop_cmd && !pre_cmd); // [RULE19]
    assign last = bl_reg != sdcb_pkg::BL_PAGE && cur_beat == last_beat; // [RULE25]

    sdcb_col_gen u_col_gen (
        .start_i(cur_start),
        .beat_i(cur_beat),
        .bl_i(bl_reg),
        .ilv_i(ilv_reg),
        .col_o(cur_col)
    );

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            state_reg <= sdcb_pkg::SDCB_IDLE;
            bank_reg <= 2'h0;
            start_reg <= 8'h00;
            beat_reg <= 8'h00;
        end
        else if (beat_on && !last)
        begin
            state_reg <= cur_kind;
            bank_reg <= cur_bank;
            start_reg <= cur_start;
            beat_reg <= cur_beat + 8'h01;
        end
        else
            state_reg <= sdcb_pkg::SDCB_IDLE; // [RULE14]
    end

    // ======================================================================
    // Array request, registered
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
            MEM_REQ_O <= '0;
        else
        begin
            MEM_REQ_O.re <= beat_on && cur_kind == sdcb_pkg::SDCB_READ;
            MEM_REQ_O.we <= beat_on && cur_kind == sdcb_pkg::SDCB_WRITE && DQM_I != 4'hf; // [RULE14]
            MEM_REQ_O.be <= ~DQM_I; // [RULE23]
            MEM_REQ_O.bank <= cur_bank;
            MEM_REQ_O.row <= row_reg[cur_bank];
            MEM_REQ_O.col <= cur_col;
            MEM_REQ_O.wdata <= DQ_I;
        end
    end

    // ======================================================================
    // Read data pipe and output enables
    logic rd_v1_reg;
    logic rd_v2_reg;
    logic [31:0] rd_d1_reg;
    logic [31:0] rd_d2_reg;
    logic [3:0] dqm_d1_reg;
    logic [3:0] dqm_d2_reg;
    logic out_v;

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            rd_v1_reg <= 1'b0;
            rd_v2_reg <= 1'b0;
            rd_d1_reg <= 32'h0000_0000;
            rd_d2_reg <= 32'h0000_0000;
        end
        else
        begin
            rd_v1_reg <= MEM_REQ_O.re;
            rd_v2_reg <= rd_v1_reg;
            rd_d1_reg <= MEM_RDATA_I;
            rd_d2_reg <= rd_d1_reg;
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            dqm_d1_reg <= 4'h0;
            dqm_d2_reg <= 4'h0;
        end
        else
        begin
            dqm_d1_reg <= DQM_I;
            dqm_d2_reg <= dqm_d1_reg;
        end
    end

    // Beats stop at once on burst stop, so the pins float exactly one latency later.
    assign out_v = cl3_reg ? rd_v2_reg : rd_v1_reg; // [RULE15] [RULE20]
    assign DQ_O = cl3_reg ? rd_d2_reg : rd_d1_reg;
    assign DQ_OE_O = {4{out_v}} & ~dqm_d2_reg; // [RULE23]

    // ======================================================================
    // Checks
    logic [10:0] addr_d1_reg;
    logic [10:0] addr_d2_reg;

    always_ff @(posedge CORE_CLK_I)
    begin
        addr_d1_reg <= ADDR_I;
        addr_d2_reg <= addr_d1_reg;
    end

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    mode_load_a: assert property (cmd_ok && op == sdcb_pkg::OP_MODE_SET |=> bl_reg == $past(ADDR_I[2:0])) // [RULE4]
        else $error("Mode word not loaded from the address pins.");
    col_access_a: assert property (col_cmd |=> MEM_REQ_O.col == $past(ADDR_I[7:0])
        && MEM_REQ_O.re == $past(WE_N_I)) // [RULE10]
        else $error("Column access start column or direction wrong.");
    back_to_back_a: assert property (col_cmd ##1 col_cmd |=> MEM_REQ_O.col == addr_d1_reg[7:0]) // [RULE12]
        else $error("Back to back column command not taken.");
    write_data_a: assert property (cmd_ok && op == sdcb_pkg::OP_WRITE && DQM_I == 4'h0
        |=> MEM_REQ_O.we && MEM_REQ_O.wdata == $past(DQ_I)) // [RULE14]
        else $error("Write data of the command cycle lost.");
    seq_wrap_a: assert property (col_cmd && bl_reg == sdcb_pkg::BL_8 && !ilv_reg ##1 !col_cmd && !stop_cmd && !pre_cmd
        |=> MEM_REQ_O.col == {addr_d2_reg[7:3], addr_d2_reg[2:0] + 3'h1}) // [RULE21]
        else $error("Sequential beat carried out of its block.");
    ilv_beat_a: assert property (col_cmd && (bl_reg == sdcb_pkg::BL_4 || bl_reg == sdcb_pkg::BL_8) && ilv_reg
        ##1 !col_cmd && !stop_cmd && !pre_cmd
        |=> MEM_REQ_O.col == (addr_d2_reg[7:0] ^ 8'h01)) // [RULE22]
        else $error("Interleaved beat column wrong.");
    rd_mask_a: assert property (DQM_I[0] |-> ##2 !DQ_OE_O[0]) // [RULE23]
        else $error("Read mask did not float the byte two cycles later.");
    wr_mask_a: assert property (state_reg == sdcb_pkg::SDCB_WRITE && !col_cmd && DQM_I == 4'hf |=> !MEM_REQ_O.we) // [RULE23]
        else $error("Masked write beat reached the array.");
    deselect_a: assert property (CS_N_I && state_reg == sdcb_pkg::SDCB_IDLE |=> !MEM_REQ_O.re && !MEM_REQ_O.we) // [RULE24]
        else $error("Command taken while deselected.");
    stop_end_a: assert property (stop_cmd |=> !MEM_REQ_O.re && !MEM_REQ_O.we) // [RULE19]
        else $error("Burst continued after burst stop.");
    stop_float_a: assert property (stop_cmd && !cl3_reg ##1 !col_cmd |=> DQ_OE_O == 4'h0) // [RULE20]
        else $error("Outputs not floated one latency after burst stop.");

    page_run_c: cover property (bl_reg == sdcb_pkg::BL_PAGE && state_reg == sdcb_pkg::SDCB_READ && beat_reg == 8'hff);
    rd_after_wr_c: cover property (state_reg == sdcb_pkg::SDCB_WRITE && col_cmd && WE_N_I);
    cl3_read_c: cover property (cl3_reg && DQ_OE_O == 4'hf);
    stop_read_c: cover property (stop_cmd && state_reg == sdcb_pkg::SDCB_READ);
endmodule // sdcb_core

// ===== hdl/sdcb_pkg.sv
// Purpose: Shared constants and types for the synchronous DRAM command and burst core.
// Assumes: One clock; controller pins are synchronous to it.
// Notes: Mode word layout and latency codes are fixed here for both design files.
package sdcb_pkg;
    // ======================================================================
    // Widths
    localparam int ROW_W = 11;
    localparam int COL_W = 8;
    localparam int BANK_W = 2;
    localparam int BANKS = 4;
    localparam int DATA_W = 32;
    localparam int MASK_W = 4;

    // ======================================================================
    // Mode word fields and reset values
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] CL_THREE = 3'h3;
    localparam logic [2:0] BL_RST = BL_1;
    localparam logic BT_RST = 1'b0;
    localparam logic CL3_RST = 1'b0;

    // ======================================================================
    // Command codes as {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] OP_MODE_SET = 4'h0;
    localparam logic [3:0] OP_PRECHARGE = 4'h2;
    localparam logic [3:0] OP_ACTIVATE = 4'h3;
    localparam logic [3:0] OP_WRITE = 4'h4;
    localparam logic [3:0] OP_READ = 4'h5;
    localparam logic [3:0] OP_BURST_STOP = 4'h6;
    localparam int PRE_ALL_BIT = 10;

    // ======================================================================
    // Types
    typedef enum {SDCB_IDLE, SDCB_READ, SDCB_WRITE} sdcb_burst_t;

    typedef struct packed {
        logic re;
        logic we;
        logic [MASK_W-1:0] be;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [DATA_W-1:0] wdata;
    } sdcb_mem_req_t;
endpackage

// ===== testbench/sdcb_ctrl_model.sv
// Purpose: Behavioural memory controller that drives the command, mask and data pins.
// Assumes: Every task is entered 1 ns after a rising edge and returns 1 ns after a rising edge.
// Notes: Timing gaps are parameters; the device does not check them.
module sdcb_ctrl_model #(
    parameter int INIT_WAIT = 5000,
    parameter int MODE_GAP = 2,
    parameter int RCD_GAP = 3,
    parameter int RC_GAP = 6
) (
    input wire logic clk_i,
    output logic cke_o,
    output logic [3:0] strobe_o,
    output logic [1:0] bank_o,
    output logic [10:0] addr_o,
    output logic [3:0] dqm_o,
    output logic [31:0] dq_o,
    output logic dq_en_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================================
    // Pin drivers
    initial
    begin
        cke_o = 1'b1;
        strobe_o = 4'h7;
        bank_o = 2'h0;
        addr_o = 11'h000;
        dqm_o = 4'hf;
        dq_o = 32'h0;
        dq_en_o = 1'b0;
    end

    // The bus is released whenever drv is low, so no stale data lingers.
    task automatic cmd(input logic [3:0] op, input logic [1:0] bk, input logic [10:0] ad,
                       input logic [3:0] mk, input logic drv, input logic [31:0] d);
        strobe_o = op;
        bank_o = bk;
        addr_o = ad;
        dqm_o = mk;
        dq_en_o = drv;
        dq_o = d;
        @(posedge clk_i);
        #1;
    endtask

    task automatic idle(input int n);
        repeat (n) cmd(4'h7, 2'h0, 11'h000, 4'h0, 1'b0, 32'h0);
    endtask

    task automatic nopd(input logic [3:0] mk, input logic [31:0] d);
        cmd(4'h7, 2'h0, 11'h000, mk, 1'b1, d);
    endtask

    // A low clock enable for one cycle voids the command of the cycle after.
    task automatic cke_drop();
        cke_o = 1'b0;
        idle(1);
        cke_o = 1'b1;
    endtask

    // =====================================================================
    // Sequences
    task automatic power_up();
        repeat (INIT_WAIT) cmd(4'h7, 2'h0, 11'h000, 4'hf, 1'b0, 32'h0);
        cmd(4'h2, 2'h0, 11'h400, 4'hf, 1'b0, 32'h0);
        idle(2);
        repeat (8)
        begin
            cmd(4'h1, 2'h0, 11'h000, 4'h0, 1'b0, 32'h0);
            idle(RC_GAP);
        end
    endtask

    task automatic set_mode(input logic [10:0] word);
        cmd(4'h2, 2'h0, 11'h400, 4'h0, 1'b0, 32'h0);
        idle(RC_GAP);
        cmd(4'h0, 2'h0, word, 4'h0, 1'b0, 32'h0);
        idle(MODE_GAP);
    endtask

    task automatic open_row(input logic [1:0] bk, input logic [10:0] row);
        cmd(4'h3, bk, row, 4'h0, 1'b0, 32'h0);
        idle(RCD_GAP);
    endtask
endmodule // sdcb_ctrl_model

// ===== testbench/sdram_command_burst_core_tb_top.sv
// Purpose: Self-checking bench of the command decoder and burst sequencer.
// Assumes: Write byte enables are the inverse of the masks.
// Notes: Outputs are logged at every falling edge and judged against the command stamp.
module sdram_command_burst_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================================
    // Harness
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cke;
    logic [3:0] stb;
    logic [1:0] bk;
    logic [10:0] ad;
    logic [3:0] dqm;
    logic [31:0] c_dq;
    logic c_en;
    logic [31:0] dq_out;
    logic [3:0] dq_oe;
    logic [31:0] dq_wire;
    logic [31:0] junk = 32'h0f0f0f0f;
    logic [31:0] rdata;
    sdcb_pkg::sdcb_mem_req_t req;
    sdcb_pkg::sdcb_mem_req_t req_q [8192];
    logic [31:0] dq_q [8192];
    logic [3:0] oe_q [8192];
    int ncyc = 0;
    int err_total = 0;
    int total_checks = 0;

    always #20 clk = ~clk;
    always @(posedge clk) junk <= ~junk;

    function automatic logic [31:0] dat(input logic [7:0] c);
        return {~c, c ^ 8'h5a, c ^ 8'ha5, c};
    endfunction

    assign rdata = dat(req.col);

    // A byte nobody drives shows a toggling pattern rather than a held value.
    always_comb
    begin
        for (int b = 0; b < 4; b++)
            dq_wire[8*b +: 8] = dq_oe[b] ? dq_out[8*b +: 8] : (c_en ? c_dq[8*b +: 8] : junk[8*b +: 8]);
    end

    sdcb_ctrl_model ctrl (.clk_i(clk), .cke_o(cke), .strobe_o(stb), .bank_o(bk), .addr_o(ad),
                          .dqm_o(dqm), .dq_o(c_dq), .dq_en_o(c_en));

    sdcb_core dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CKE_I(cke), .CS_N_I(stb[3]), .RAS_N_I(stb[2]),
                   .CAS_N_I(stb[1]), .WE_N_I(stb[0]), .BANK_SELECT_I(bk), .ADDR_I(ad), .DQM_I(dqm),
                   .DQ_I(dq_wire), .DQ_O(dq_out), .DQ_OE_O(dq_oe), .MEM_REQ_O(req), .MEM_RDATA_I(rdata));

    always @(negedge clk)
    begin
        ncyc = ncyc + 1;
        req_q[ncyc] = req;
        dq_q[ncyc] = dq_out;
        oe_q[ncyc] = dq_oe;
        if (ncyc > 8000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    // =====================================================================
    // Checking helpers
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_beat(input int ts, input int k, input logic [7:0] col, input int lat);
        chk({req_q[ts+2+k].re, req_q[ts+2+k].col}, {1'b1, col});
        chk({oe_q[ts+1+lat+k], dq_q[ts+1+lat+k]}, {4'hf, dat(col)});
    endtask

    task automatic wr_beat(input int ts, input int k, input logic [7:0] col, input logic [31:0] d,
                           input logic [3:0] be);
        chk({req_q[ts+2+k].we, req_q[ts+2+k].col, req_q[ts+2+k].wdata, req_q[ts+2+k].be},
            {1'b1, col, d, be});
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // =====================================================================
    // Scenarios
    task automatic t_seq();
        int ts;
        int n;
        logic [7:0] m;
        for (int i = 0; i < 4; i++)
        begin
            n = 1 << i;
            m = 8'(n - 1);
            ctrl.set_mode({4'h0, 3'h2, 1'b0, 3'(i)});
            ctrl.open_row(2'h1, 11'h005);
            ts = ncyc;
            ctrl.cmd(4'h5, 2'h1, 11'h02d, 4'h0, 1'b0, 32'h0);
            ctrl.idle(12);
            for (int k = 0; k < n; k++)
                rd_beat(ts, k, (8'h2d & ~m) | ((8'h2d + 8'(k)) & m), 2);
            chk(req_q[ts+2+n].re, 1'b0);
            chk(oe_q[ts+3+n], 4'h0);
        end
        ctrl.set_mode({4'h0, 3'h3, 1'b1, 3'h3});
        ctrl.open_row(2'h2, 11'h123);
        ts = ncyc;
        ctrl.cmd(4'h5, 2'h2, 11'h013, 4'h0, 1'b0, 32'h0);
        ctrl.idle(14);
        for (int k = 0; k < 8; k++)
            rd_beat(ts, k, 8'h13 ^ 8'(k), 3);
        chk(oe_q[ts+12], 4'h0);
        $display("burst order test done");
    endtask

    task automatic t_write();
        int ts;
        ctrl.set_mode({4'h0, 3'h2, 1'b0, 3'h1});
        ctrl.open_row(2'h0, 11'h00a);
        ts = ncyc;
        ctrl.cmd(4'h4, 2'h0, 11'h003, 4'h0, 1'b1, 32'haaaa0001);
        ctrl.nopd(4'h1, 32'hbbbb0002);
        ctrl.nopd(4'h0, 32'hcccc0003);
        ctrl.cmd(4'h4, 2'h0, 11'h010, 4'hf, 1'b1, 32'hdddd0004);
        ctrl.nopd(4'h0, 32'heeee0005);
        ctrl.idle(6);
        wr_beat(ts, 0, 8'h03, 32'haaaa0001, 4'hf);
        wr_beat(ts, 1, 8'h02, 32'hbbbb0002, 4'he);
        chk(req_q[ts+4].we, 1'b0);
        chk(req_q[ts+5].we, 1'b0);
        wr_beat(ts + 3, 1, 8'h11, 32'heeee0005, 4'hf);
        $display("write test done");
    endtask

    task automatic t_cut();
        int ts;
        ctrl.set_mode({4'h0, 3'h2, 1'b0, 3'h2});
        ctrl.open_row(2'h1, 11'h0aa);
        ctrl.open_row(2'h2, 11'h0bb);
        ts = ncyc;
        ctrl.cmd(4'h5, 2'h1, 11'h000, 4'h0, 1'b0, 32'h0);
        ctrl.idle(1);
        ctrl.cmd(4'h5, 2'h2, 11'h008, 4'h0, 1'b0, 32'h0);
        ctrl.cmd(4'h7, 2'h0, 11'h000, 4'hf, 1'b0, 32'h0);
        ctrl.cmd(4'h7, 2'h0, 11'h000, 4'hf, 1'b0, 32'h0);
        ctrl.cmd(4'h4, 2'h1, 11'h000, 4'h0, 1'b1, 32'h11110000);
        ctrl.nopd(4'h0, 32'h11110001);
        ctrl.cmd(4'h4, 2'h1, 11'h020, 4'h0, 1'b1, 32'h22220000);
        for (int k = 1; k < 4; k++)
            ctrl.nopd(4'h0, 32'h22220000 + k);
        ctrl.cmd(4'h4, 2'h2, 11'h040, 4'h0, 1'b1, 32'h33330000);
        ctrl.cmd(4'h5, 2'h2, 11'h044, 4'h0, 1'b0, 32'h0);
        ctrl.idle(8);
        rd_beat(ts, 0, 8'h00, 2);
        rd_beat(ts, 1, 8'h01, 2);
        rd_beat(ts + 2, 0, 8'h08, 2);
        chk(req_q[ts+4].bank, 2'h2);
        chk({oe_q[ts+6], oe_q[ts+7]}, 8'h00);
        wr_beat(ts + 5, 0, 8'h00, 32'h11110000, 4'hf);
        wr_beat(ts + 5, 1, 8'h01, 32'h11110001, 4'hf);
        for (int k = 0; k < 4; k++)
            wr_beat(ts + 7, k, 8'h20 + 8'(k), 32'h22220000 + k, 4'hf);
        wr_beat(ts + 11, 0, 8'h40, 32'h33330000, 4'hf);
        chk(req_q[ts+14].we, 1'b0);
        for (int k = 0; k < 4; k++)
            rd_beat(ts + 12, k, 8'h44 + 8'(k), 2);
        $display("interrupt test done");
    endtask

    task automatic t_page();
        int ts;
        ctrl.set_mode({4'h0, 3'h2, 1'b0, 3'h7});
        ctrl.open_row(2'h3, 11'h077);
        ts = ncyc;
        ctrl.cmd(4'h5, 2'h3, 11'h0fe, 4'h0, 1'b0, 32'h0);
        ctrl.idle(2);
        ctrl.cmd(4'h6, 2'h0, 11'h000, 4'h0, 1'b0, 32'h0);
        ctrl.idle(6);
        for (int k = 0; k < 3; k++)
            rd_beat(ts, k, 8'hfe + 8'(k), 2);
        chk(req_q[ts+2].row, 11'h077);
        chk(req_q[ts+5].re, 1'b0);
        chk(oe_q[ts+6], 4'h0);
        ts = ncyc;
        ctrl.cmd(4'h5, 2'h3, 11'h030, 4'h0, 1'b0, 32'h0);
        ctrl.idle(1);
        ctrl.cmd(4'h6, 2'h0, 11'h000, 4'h0, 1'b0, 32'h0);
        ctrl.idle(5);
        rd_beat(ts, 1, 8'h31, 2);
        chk(req_q[ts+3].row, 11'h077);
        chk(oe_q[ts+5], 4'h0);
        // A reset in mid-burst must end the burst and clear the pins.
        ts = ncyc;
        ctrl.cmd(4'h5, 2'h3, 11'h040, 4'h0, 1'b0, 32'h0);
        ctrl.idle(1);
        rst_n = 1'b0;
        ctrl.idle(2);
        rst_n = 1'b1;
        ctrl.idle(3);
        rd_beat(ts, 0, 8'h40, 2);
        chk({req_q[ts+4].re, oe_q[ts+4]}, 5'h00);
        chk({req_q[ts+6].re, oe_q[ts+7]}, 5'h00);
        $display("page and stop test done");
    endtask

    task automatic t_desel_mask();
        int ts;
        logic [31:0] e;
        e = dat(8'h01);
        ctrl.set_mode({4'h0, 3'h2, 1'b0, 3'h2});
        ctrl.cke_drop();
        ctrl.cmd(4'h0, 2'h0, 11'h020, 4'h0, 1'b0, 32'h0);
        ctrl.idle(2);
        ctrl.open_row(2'h1, 11'h0cc);
        ts = ncyc;
        ctrl.cmd(4'h5, 2'h1, 11'h050, 4'h0, 1'b0, 32'h0);
        ctrl.cmd(4'hd, 2'h1, 11'h070, 4'h0, 1'b0, 32'h0);
        ctrl.cmd(4'h8, 2'h1, 11'h000, 4'h0, 1'b0, 32'h0);
        ctrl.idle(2);
        ctrl.cmd(4'hd, 2'h1, 11'h070, 4'h0, 1'b0, 32'h0);
        ctrl.idle(3);
        for (int k = 0; k < 4; k++)
            rd_beat(ts, k, 8'h50 + 8'(k), 2);
        chk(req_q[ts+6].re, 1'b0);
        chk(req_q[ts+7].re, 1'b0);
        chk(req_q[ts+5].re, 1'b1);
        ts = ncyc;
        ctrl.cmd(4'h5, 2'h1, 11'h000, 4'h0, 1'b0, 32'h0);
        ctrl.cmd(4'h7, 2'h0, 11'h000, 4'h3, 1'b0, 32'h0);
        ctrl.idle(6);
        chk(oe_q[ts+3], 4'hf);
        chk({oe_q[ts+4], dq_q[ts+4][31:16]}, {4'hc, e[31:16]});
        chk(oe_q[ts+5], 4'hf);
        ts = ncyc;
        ctrl.cmd(4'h5, 2'h1, 11'h000, 4'hf, 1'b0, 32'h0);
        ctrl.idle(0);
        ctrl.cmd(4'h7, 2'h0, 11'h000, 4'hf, 1'b0, 32'h0);
        ctrl.cmd(4'h7, 2'h0, 11'h000, 4'hf, 1'b0, 32'h0);
        ctrl.cmd(4'h4, 2'h1, 11'h060, 4'hf, 1'b1, 32'h55550000);
        ctrl.nopd(4'hf, 32'h55550001);
        ctrl.nopd(4'h0, 32'h55550002);
        ctrl.nopd(4'h0, 32'h55550003);
        ctrl.idle(4);
        for (int j = 3; j < 6; j++)
            chk(oe_q[ts+j], 4'h0);
        chk(req_q[ts+5].we, 1'b0);
        wr_beat(ts + 3, 2, 8'h62, 32'h55550002, 4'hf);
        wr_beat(ts + 3, 3, 8'h63, 32'h55550003, 4'hf);
        $display("deselect and mask test done");
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        ctrl.power_up();
        t_seq();
        t_write();
        t_cut();
        t_page();
        t_desel_mask();
        report_and_stop();
    end
endmodule // sdram_command_burst_core_tb_top
